// file: common/dpt_pkg.sv
// constants, types and helpers shared by the page translator files
package dpt_pkg;

	// widths and top bit index of the address paths
	localparam int unsigned EA_W   = 16;
	localparam int unsigned SEL_W  = 10;
	localparam int unsigned EXT_W  = 24;
	localparam int unsigned OFS_W  = 15;
	localparam int unsigned EA_HI  = 15;

	// selector values with special handling at page boundaries
	localparam logic [9:0] SEL_ZERO      = 10'h000;
	localparam logic [9:0] SEL_RESET     = 10'h001;
	localparam logic [9:0] SEL_EDS_FIRST = 10'h001;
	localparam logic [9:0] SEL_EDS_LAST  = 10'h1FF;
	localparam logic [9:0] SEL_LSW_FIRST = 10'h200;
	localparam logic [9:0] SEL_LSW_LAST  = 10'h2FF;
	localparam logic [9:0] SEL_MSW_FIRST = 10'h300;
	localparam logic [9:0] SEL_MSW_LAST  = 10'h3FF;
	localparam logic [9:0] SEL_ONE       = 10'h001;

	// field positions inside a selector
	localparam int unsigned SEL_CODE_BIT = 9;
	localparam int unsigned SEL_MSW_BIT  = 8;

	// page zero prefix of the extended address
	localparam logic [8:0] PAGE0_PREFIX = 9'h000;

	// addressing modes reported by the address generator
	typedef enum logic [2:0] {
		mode_plain,
		mode_pre_post,
		mode_reg_offset,
		mode_modulo,
		mode_bit_rev
	} dpt_mode_t;

	// trap causes
	typedef enum logic [1:0] {
		cause_none,
		cause_page_zero,
		cause_code_write
	} dpt_cause_t;

	// selector points at the code memory window
	function automatic logic is_code_sel(input logic [9:0] sel);
		return sel[SEL_CODE_BIT];
	endfunction

	// modes that wrap inside the current page
	function automatic logic is_wrap_mode(input dpt_mode_t mode);
		return (mode == mode_reg_offset) || (mode == mode_modulo) || (mode == mode_bit_rev);
	endfunction

endpackage

// file: hw/dpt_addr_map.sv
// maps a selector and effective address onto the memory map
`timescale 1ns/10ps
`default_nettype none
module dpt_addr_map
	import dpt_pkg::*;
(
	input  wire logic [9:0]  sel,        // selector used for the access
	input  wire logic [15:0] ea,         // corrected effective address
	input  wire logic        is_write,   // access is a write
	output logic [23:0]      ext_addr,   // extended data space address
	output logic [23:0]      code_addr,  // code memory window address
	output logic             to_code,    // access goes to the code window
	output logic             code_msw,   // upper word half of code memory
	output dpt_cause_t       cause       // trap cause, none when legal
);

	logic windowed;

	assign windowed = ea[EA_HI];

	// lower half always hits page zero; upper half uses the selector
	always_comb begin
		if (windowed) begin
			ext_addr = {sel[8:0], ea[OFS_W-1:0]};
		end else begin
			ext_addr = {PAGE0_PREFIX, ea[OFS_W-1:0]};
		end
		code_addr = {1'b0, sel[7:0], ea[OFS_W-1:0]};
		to_code   = windowed && is_code_sel(sel);
		code_msw  = windowed && is_code_sel(sel) && sel[SEL_MSW_BIT];
		if (windowed && sel == SEL_ZERO) begin
			cause = cause_page_zero;
		end else if (windowed && is_write && is_code_sel(sel)) begin
			cause = cause_code_write;
		end else begin
			cause = cause_none;
		end
	end

endmodule
`default_nettype wire

// file: hw/dpt_page_step.sv
// combinational page carry and borrow for one access
`timescale 1ns/10ps
`default_nettype none
module dpt_page_step
	import dpt_pkg::*;
(
	input  wire logic [9:0]  sel_in,      // active selector before the access
	input  wire logic        is_write,    // access is a write
	input  wire dpt_mode_t   mode,        // addressing mode
	input  wire logic        adj_up,      // pointer moved upward
	input  wire logic [15:0] ea_before,   // pointer before modification
	input  wire logic [15:0] ea_after,    // pointer after modification
	output logic [9:0]       sel_out,     // selector after the access
	output logic [15:0]      ea_out,      // corrected effective address
	output logic             carry_up,    // page incremented
	output logic             carry_down,  // page decremented
	output logic             to_base      // access fell back to base space
);

	logic crossing;
	logic ea_hi;

	// a page edge is crossed when a windowed pointer leaves the upper half
	assign crossing = ea_before[EA_HI] && !ea_after[EA_HI] && (sel_in != SEL_ZERO)
		&& (mode != mode_plain);

	// boundary handling per mode and direction
	always_comb begin
		sel_out    = sel_in;
		ea_hi      = ea_after[EA_HI];
		carry_up   = 1'b0;
		carry_down = 1'b0;
		to_base    = 1'b0;
		if (crossing) begin
			if (is_wrap_mode(mode)) begin
				ea_hi = 1'b1;
			end else if (adj_up) begin
				if ((sel_in == SEL_EDS_LAST) || (!is_write && sel_in == SEL_MSW_LAST)) begin
					ea_hi   = 1'b0;
					to_base = 1'b1;
				end else if (!is_write && sel_in == SEL_LSW_LAST) begin
					sel_out  = SEL_MSW_FIRST;
					ea_hi    = 1'b1;
					carry_up = 1'b1; // still a one-page step upward
				end else begin
					sel_out  = sel_in + SEL_ONE;
					ea_hi    = 1'b1;
					carry_up = 1'b1;
				end
			end else begin
				if (sel_in == SEL_EDS_FIRST || (!is_write && sel_in == SEL_LSW_FIRST)) begin
					ea_hi   = 1'b0;
					to_base = 1'b1;
				end else if (!is_write && sel_in == SEL_MSW_FIRST) begin
					sel_out    = SEL_LSW_LAST;
					ea_hi      = 1'b1;
					carry_down = 1'b1; // still a one-page step downward
				end else begin
					sel_out    = sel_in - SEL_ONE;
					ea_hi      = 1'b1;
					carry_down = 1'b1;
				end
			end
		end
		ea_out = {ea_hi, ea_after[OFS_W-1:0]};
	end

endmodule
`default_nettype wire

// file: hw/dpt_translator.sv
// data space page translator top: selectors, carry and address mapping
//
// Overview of operation
// - separate read and write page selectors
// - carried overflow increments selector, sets bit 15
// - carried underflow decrements selector, sets bit 15
// - offset, modulo, bit-reversed wrap within page
// - boundary crossings at edges fall to base space
// - read carry bridges 0x2FF and 0x300 pages
// - upper-half access with selector zero traps
// - writes into code window trap
// - lower half always maps to page zero
// - both selectors reset to one
// - software write of zero is ignored
// - upper half maps selector pages, 32K each
`timescale 1ns/10ps
`default_nettype none
module dpt_translator
	import dpt_pkg::*;
(
	input  wire logic        core_clk,      // core clock
	input  wire logic        rst,           // synchronous reset, active high
	input  wire logic        req_valid,     // access request from the address generator
	input  wire logic        req_write,     // request is a write
	input  wire dpt_mode_t   req_mode,      // addressing mode of the request
	input  wire logic        req_adj_up,    // pointer adjusted upward
	input  wire logic [15:0] req_ea_before, // pointer before modification
	input  wire logic [15:0] req_ea_after,  // pointer after modification
	input  wire logic        sw_wr_en,      // software selector write strobe
	input  wire logic        sw_wr_dest,    // write targets the destination selector
	input  wire logic [9:0]  sw_wr_data,    // selector value to write
	output logic [9:0]       source_page_sel, // read page selector
	output logic [9:0]       dest_page_sel,   // write page selector
	output logic             rsp_valid,     // translated access valid
	output logic             rsp_write,     // translated access is a write
	output logic [15:0]      rsp_ea,        // corrected effective address
	output logic [23:0]      rsp_ext_addr,  // extended data space address
	output logic [23:0]      rsp_code_addr, // code memory window address
	output logic             rsp_to_code,   // read access targets the code window; low for writes
	output logic             rsp_code_msw,  // upper code word half
	output logic             rsp_trap,      // address error trap pulse
	output dpt_cause_t       rsp_cause,     // cause of the trap
	output logic             rsp_carry_up,  // selector was incremented
	output logic             rsp_carry_down,// selector was decremented
	output logic             rsp_to_base    // access fell back to base space
);

	logic [9:0]  src_sel_reg;
	logic [9:0]  dst_sel_reg;
	logic [9:0]  src_sel_next;
	logic [9:0]  dst_sel_next;
	logic [9:0]  active_page_sel;
	logic [9:0]  step_sel;
	logic [15:0] step_ea;
	logic        step_up;
	logic        step_down;
	logic        step_base;
	logic [23:0] map_ext;
	logic [23:0] map_code;
	logic        map_to_code;
	logic        map_msw;
	dpt_cause_t  map_cause;
	logic        trap_now;
	logic        sw_src_ok;
	logic        sw_dst_ok;

	// reads use the source selector, writes the destination selector
	assign active_page_sel = req_write ? dst_sel_reg : src_sel_reg;

	// boundary carry and borrow for the current access
	dpt_page_step u_step (
		.sel_in     (active_page_sel),
		.is_write   (req_write),
		.mode       (req_mode),
		.adj_up     (req_adj_up),
		.ea_before  (req_ea_before),
		.ea_after   (req_ea_after),
		.sel_out    (step_sel),
		.ea_out     (step_ea),
		.carry_up   (step_up),
		.carry_down (step_down),
		.to_base    (step_base)
	);

	// memory map lookup with the page the access really lands in
	dpt_addr_map u_map (
		.sel       (step_sel),
		.ea        (step_ea),
		.is_write  (req_write),
		.ext_addr  (map_ext),
		.code_addr (map_code),
		.to_code   (map_to_code),
		.code_msw  (map_msw),
		.cause     (map_cause)
	);

	assign trap_now = req_valid && (map_cause != cause_none);

	// software writes of zero leave the selector alone
	assign sw_src_ok = sw_wr_en && !sw_wr_dest && (sw_wr_data != SEL_ZERO);
	assign sw_dst_ok = sw_wr_en && sw_wr_dest && (sw_wr_data != SEL_ZERO);

	// next selector values; a software write beats a same-cycle carry
	always_comb begin
		src_sel_next = src_sel_reg;
		dst_sel_next = dst_sel_reg;
		if (req_valid && !trap_now) begin
			if (req_write) begin
				dst_sel_next = step_sel;
			end else begin
				src_sel_next = step_sel;
			end
		end
		if (sw_src_ok) begin
			src_sel_next = sw_wr_data;
		end
		if (sw_dst_ok) begin
			dst_sel_next = sw_wr_data;
		end
	end

	// source selector register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_sel_reg <= SEL_RESET;
		end else begin
			src_sel_reg <= src_sel_next;
		end
	end

	// destination selector register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dst_sel_reg <= SEL_RESET;
		end else begin
			dst_sel_reg <= dst_sel_next;
		end
	end

	assign source_page_sel = src_sel_reg;
	assign dest_page_sel   = dst_sel_reg;

	// handshake of the translated access
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_write <= 1'b0;
		end else begin
			rsp_valid <= req_valid && !trap_now;
			rsp_write <= req_valid && req_write;
		end
	end

	// translated addresses, held from the last access
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rsp_ea        <= 16'h0000;
			rsp_ext_addr  <= 24'h000000;
			rsp_code_addr <= 24'h000000;
			rsp_to_code   <= 1'b0;
			rsp_code_msw  <= 1'b0;
		end else if (req_valid) begin
			rsp_ea        <= step_ea;
			rsp_ext_addr  <= map_ext;
			rsp_code_addr <= map_code;
			rsp_to_code   <= map_to_code && !req_write;
			rsp_code_msw  <= map_msw;
		end
	end

	// trap and boundary event pulses
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rsp_trap       <= 1'b0;
			rsp_cause      <= cause_none;
			rsp_carry_up   <= 1'b0;
			rsp_carry_down <= 1'b0;
			rsp_to_base    <= 1'b0;
		end else begin
			rsp_trap       <= trap_now;
			rsp_cause      <= trap_now ? map_cause : cause_none;
			rsp_carry_up   <= req_valid && !trap_now && step_up;
			rsp_carry_down <= req_valid && !trap_now && step_down;
			rsp_to_base    <= req_valid && !trap_now && step_base;
		end
	end

endmodule
`default_nettype wire

// file: verif/dpt_agen_model.sv
// address generator model issuing translator requests
`timescale 1ns/10ps
`default_nettype none
module dpt_agen_model
	import dpt_pkg::*;
(
	input  wire logic   core_clk,      // clock
	output logic        req_valid,     // request
	output logic        req_write,     // write
	output dpt_mode_t   req_mode,      // mode
	output logic        req_adj_up,    // upward
	output logic [15:0] req_ea_before, // old pointer
	output logic [15:0] req_ea_after   // new pointer
);
	// idle at time zero
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_mode = mode_plain;
		req_adj_up = 1'b0;
		req_ea_before = 16'h0000;
		req_ea_after = 16'h0000;
	end
	// one request per edge, pointers driven exactly as given
	task automatic put(input logic w, input dpt_mode_t m, input logic up, input logic [15:0] b, a);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_mode <= m;
		req_adj_up <= up;
		req_ea_before <= b;
		req_ea_after <= a;
	endtask
	// release: pointer lines stop showing the old value
	task automatic rel();
		@(posedge core_clk);
		req_valid <= 1'b0;
		req_ea_before <= ~req_ea_before;
		req_ea_after <= ~req_ea_after;
	endtask
endmodule
`default_nettype wire

// file: verif/dpt_translator_monitor.sv
// assertion checker on the page translator ports
`timescale 1ns/10ps
`default_nettype none
module dpt_translator_monitor
	import dpt_pkg::*;
(
	input wire logic        core_clk,        // clock
	input wire logic        rst,             // reset
	input wire logic        req_valid,       // request
	input wire logic        req_write,       // write
	input wire dpt_mode_t   req_mode,        // mode
	input wire logic        req_adj_up,      // upward
	input wire logic [15:0] req_ea_before,   // old pointer
	input wire logic [15:0] req_ea_after,    // new pointer
	input wire logic        sw_wr_en,        // sw write
	input wire logic [9:0]  source_page_sel, // read page
	input wire logic [9:0]  dest_page_sel,   // write page
	input wire logic        rsp_valid,       // done
	input wire logic        rsp_trap,        // trap
	input wire dpt_cause_t  rsp_cause,       // cause
	input wire logic [15:0] rsp_ea,          // ea
	input wire logic [23:0] rsp_ext_addr,    // ext address
	input wire logic        rsp_carry_up,    // inc
	input wire logic        rsp_carry_down,  // dec
	input wire logic        rsp_to_base      // base
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// a request whose pointer leaves the upper half
	sequence s_cross;
		req_valid && !sw_wr_en && req_ea_before[15] && !req_ea_after[15];
	endsequence
	// the same, as a carrying read
	sequence s_rd_pp;
		s_cross ##0 (!req_write && req_mode == mode_pre_post);
	endsequence
	// selector, trap, mapping and boundary properties
	property p_reset_sel;
		$fell(rst) |-> source_page_sel == SEL_RESET && dest_page_sel == SEL_RESET;
	endproperty
	property p_nonzero;
		source_page_sel != SEL_ZERO && dest_page_sel != SEL_ZERO;
	endproperty
	property p_code_wr;
		req_valid && req_write && req_mode == mode_plain && req_ea_after[15] && dest_page_sel[9]
			|=> rsp_trap && !rsp_valid && rsp_cause == cause_code_write;
	endproperty
	property p_low;
		req_valid && !req_ea_before[15] && !req_ea_after[15]
			|=> rsp_ext_addr == {9'h000, $past(req_ea_after[14:0])};
	endproperty
	property p_up_map;
		req_valid && !req_write && req_mode == mode_plain && req_ea_after[15] && !source_page_sel[9]
			|=> rsp_valid && rsp_ext_addr == {$past(source_page_sel[8:0]), $past(req_ea_after[14:0])};
	endproperty
	property p_inc;
		s_rd_pp ##0 (req_adj_up && source_page_sel inside {[10'h001:10'h1FE]})
			|=> rsp_carry_up && rsp_ea[15] && source_page_sel == $past(source_page_sel) + 10'h001;
	endproperty
	property p_dec;
		s_rd_pp ##0 (!req_adj_up && source_page_sel inside {[10'h002:10'h1FF]})
			|=> rsp_carry_down && rsp_ea[15] && source_page_sel == $past(source_page_sel) - 10'h001;
	endproperty
	property p_wrap;
		s_cross ##0 (!req_write && req_mode inside {mode_reg_offset, mode_modulo, mode_bit_rev})
			|=> $stable(source_page_sel) && rsp_ea[15] && !rsp_carry_up && !rsp_carry_down;
	endproperty
	property p_edge;
		s_rd_pp ##0 (req_adj_up && source_page_sel == SEL_EDS_LAST)
			|=> rsp_to_base && !rsp_ea[15] && $stable(source_page_sel);
	endproperty
	property p_bridge;
		s_rd_pp ##0 (!req_adj_up && source_page_sel == SEL_MSW_FIRST)
			|=> source_page_sel == SEL_LSW_LAST && rsp_ea[15];
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("selector not one after reset");
	a_nonzero: assert property (p_nonzero) else $error("selector reached zero");
	a_code_wr: assert property (p_code_wr) else $error("code write not trapped");
	a_low: assert property (p_low) else $error("lower half not on page zero");
	a_up_map: assert property (p_up_map) else $error("upper half map wrong");
	a_inc: assert property (p_inc) else $error("overflow carry wrong");
	a_dec: assert property (p_dec) else $error("underflow borrow wrong");
	a_wrap: assert property (p_wrap) else $error("wrap mode moved page");
	a_edge: assert property (p_edge) else $error("last page overflow wrong");
	a_bridge: assert property (p_bridge) else $error("code half bridge wrong");
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the page translator
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dpt_pkg::*;
;
	typedef struct packed {
		logic        w;   // write
		dpt_mode_t   m;   // mode
		logic        up;  // upward
		logic [9:0]  sel; // selector preset
		logic [15:0] p;   // plain pointer
		logic [9:0]  sx;  // selector after
		logic [4:0]  ev;  // valid trap up down base
	} dpt_row_t;
	logic        core_clk, rst, sw_wr_en, sw_wr_dest, req_valid, req_write, req_adj_up;
	logic        rsp_valid, rsp_trap, rsp_carry_up, rsp_carry_down, rsp_to_base;
	logic        rsp_write, rsp_to_code, rsp_code_msw, cw;
	logic [9:0]  sw_wr_data, source_page_sel, dest_page_sel;
	logic [15:0] req_ea_before, req_ea_after, rsp_ea, a, b, ex;
	logic [23:0] rsp_ext_addr, rsp_code_addr;
	dpt_mode_t   req_mode;
	dpt_cause_t  rsp_cause;
	dpt_row_t    r;
	int          error_cnt, samples_checked, i;
	dpt_row_t    rows [17] = '{
		'{1'b0, mode_pre_post, 1'b1, 10'h001, 16'h0000, 10'h002, 5'h14},
		'{1'b0, mode_pre_post, 1'b0, 10'h002, 16'h0000, 10'h001, 5'h12},
		'{1'b1, mode_pre_post, 1'b0, 10'h005, 16'h0000, 10'h004, 5'h12},
		'{1'b0, mode_modulo, 1'b1, 10'h005, 16'h0000, 10'h005, 5'h10},
		'{1'b0, mode_reg_offset, 1'b1, 10'h006, 16'h0000, 10'h006, 5'h10},
		'{1'b0, mode_bit_rev, 1'b0, 10'h004, 16'h0000, 10'h004, 5'h10},
		'{1'b0, mode_pre_post, 1'b1, 10'h1FF, 16'h0000, 10'h1FF, 5'h11},
		'{1'b1, mode_pre_post, 1'b1, 10'h1FF, 16'h0000, 10'h1FF, 5'h11},
		'{1'b0, mode_pre_post, 1'b1, 10'h3FF, 16'h0000, 10'h3FF, 5'h11},
		'{1'b0, mode_pre_post, 1'b0, 10'h001, 16'h0000, 10'h001, 5'h11},
		'{1'b0, mode_pre_post, 1'b0, 10'h200, 16'h0000, 10'h200, 5'h11},
		'{1'b0, mode_pre_post, 1'b1, 10'h2FF, 16'h0000, 10'h300, 5'h14},
		'{1'b0, mode_pre_post, 1'b0, 10'h300, 16'h0000, 10'h2FF, 5'h12},
		'{1'b0, mode_plain, 1'b1, 10'h003, 16'h1234, 10'h003, 5'h10},
		'{1'b0, mode_plain, 1'b1, 10'h007, 16'h8004, 10'h007, 5'h10},
		'{1'b1, mode_plain, 1'b1, 10'h003, 16'h8004, 10'h003, 5'h10},
		'{1'b1, mode_plain, 1'b1, 10'h200, 16'h8000, 10'h200, 5'h08}};
	dpt_translator dut (.core_clk, .rst, .req_valid, .req_write, .req_mode, .req_adj_up,
		.req_ea_before, .req_ea_after, .sw_wr_en, .sw_wr_dest, .sw_wr_data, .source_page_sel,
		.dest_page_sel, .rsp_valid, .rsp_write, .rsp_ea, .rsp_ext_addr, .rsp_code_addr,
		.rsp_to_code, .rsp_code_msw, .rsp_trap, .rsp_cause, .rsp_carry_up, .rsp_carry_down,
		.rsp_to_base);
	dpt_agen_model agen (.core_clk, .req_valid, .req_write, .req_mode, .req_adj_up,
		.req_ea_before, .req_ea_after);
	// clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// compare helpers
	task automatic chk_sel(input string n, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one-cycle software selector write
	task automatic sw(input logic d, input logic [9:0] v);
		@(posedge core_clk);
		sw_wr_en <= 1'b1;
		sw_wr_dest <= d;
		sw_wr_data <= v;
		@(posedge core_clk);
		sw_wr_en <= 1'b0;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		sw_wr_en = 1'b0;
		sw_wr_dest = 1'b0;
		sw_wr_data = 10'h000;
		error_cnt = 0;
		samples_checked = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		for (i = 0; i < 17; i++) begin
			r = rows[i];
			b = (r.m == mode_plain) ? r.p : (r.up ? 16'hFFFE : 16'h8000);
			a = (r.m == mode_plain) ? r.p : (r.up ? 16'h0000 : 16'h7FFE);
			ex = (r.ev[0] || r.m == mode_plain) ? a : {1'b1, a[14:0]};
			cw = ex[15] && r.sx[9];
			sw(r.w, r.sel);
			sw(!r.w, r.sel ^ 10'h0F0);
			agen.put(r.w, r.m, r.up, b, a);
			agen.rel();
			#1;
			chk_sel("used_sel", r.sx, r.w ? dest_page_sel : source_page_sel);
			chk_sel("other_sel", r.sel ^ 10'h0F0, r.w ? source_page_sel : dest_page_sel);
			chk_val("events", 24'(r.ev), {19'h00000, rsp_valid, rsp_trap, rsp_carry_up,
				rsp_carry_down, rsp_to_base});
			chk_val("cause", 24'(r.ev[3] ? cause_code_write : cause_none), 24'(rsp_cause));
			if (r.ev[4]) chk_val("ea", {8'h00, ex}, {8'h00, rsp_ea});
			if (r.ev[4] && !r.sx[9]) chk_val("ext", {ex[15] ? r.sx[8:0] : 9'h000, ex[14:0]},
				rsp_ext_addr);
			chk_val("write", 24'(r.w), 24'(rsp_write));
			if (r.ev[4]) chk_val("to_code", 24'(cw), 24'(rsp_to_code));
			if (r.ev[4]) chk_val("code_msw", 24'(cw && r.sx[8]), 24'(rsp_code_msw));
			if (r.ev[4] && cw) chk_val("caddr", {1'b0, r.sx[7:0], ex[14:0]}, rsp_code_addr);
		end
		// back-to-back carries see the updated selector
		sw(1'b0, 10'h001);
		agen.put(1'b0, mode_pre_post, 1'b1, 16'hFFFE, 16'h0000);
		agen.put(1'b0, mode_pre_post, 1'b1, 16'hFFFE, 16'h0000);
		agen.rel();
		#1;
		chk_sel("b2b_sel", 10'h003, source_page_sel);
		chk_val("b2b_ext", 24'h018000, rsp_ext_addr);
		// writes of zero leave the selectors alone
		sw(1'b0, 10'h000);
		sw(1'b1, 10'h000);
		#1;
		chk_sel("zero_src", 10'h003, source_page_sel);
		chk_sel("zero_dst", 10'h200, dest_page_sel);
		// second reset in mid-run
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk_sel("rst_src", SEL_RESET, source_page_sel);
		chk_sel("rst_dst", SEL_RESET, dest_page_sel);
		close_out();
	end
endmodule
bind dpt_translator dpt_translator_monitor u_mon (.core_clk, .rst, .req_valid, .req_write,
	.req_mode, .req_adj_up, .req_ea_before, .req_ea_after, .sw_wr_en, .source_page_sel,
	.dest_page_sel, .rsp_valid, .rsp_trap, .rsp_cause, .rsp_ea, .rsp_ext_addr, .rsp_carry_up,
	.rsp_carry_down, .rsp_to_base);
`default_nettype wire
